// [core/charger_status_control_regs.sv]
// charger control/status register bank with link-clock access port
`timescale 1ns/1ns
`include "charger_regs_cfg.svh"
module charger_status_control_regs #(
   parameter int unsigned SHIP_CYCLES = `SHIP_DLY_S * `CLK_HZ
) (
   input  wire logic       clk_i,          // core clock
   input  wire logic       rstn_i,         // async reset, low
   input  wire logic       link_clk_i,     // access port clock
   input  wire logic       req_valid_i,    // access request
   input  wire logic       req_write_i,    // 1 write, 0 read
   input  wire logic [7:0] req_addr_i,     // register address
   input  wire logic [7:0] req_wdata_i,    // write data
   output logic            req_ready_o,    // port idle
   output logic            resp_valid_o,   // answer pulse
   output logic            resp_ack_o,     // 1 ack, 0 nack
   output logic [7:0]      resp_rdata_o,   // read data
   input  wire logic [2:0] input_source_type_i, // source class
   input  wire logic [1:0] charge_state_i,      // charge phase
   input  wire logic       power_good_flag_i,   // power good
   input  wire logic       thermal_loop_flag_i, // thermal loop
   input  wire logic       min_system_reg_flag_i, // vsys loop
   input  wire logic       watchdog_expired_flag_i, // watchdog
   input  wire logic       bus_overload_i,      // otg overload
   input  wire logic       bus_overvoltage_i,   // bus ovp
   input  wire logic       battery_low_i,       // batt too low
   input  wire logic       input_fault_i,       // input fault
   input  wire logic       thermal_shutdown_i,  // die too hot
   input  wire logic       safety_timer_expired_i, // timer
   input  wire logic       battery_overvoltage_i,  // bat ovp
   input  wire logic [2:0] thermistor_zone_i,   // raw zone
   input  wire logic       boost_mode_i,        // in boost
   input  wire logic       bus_attached_flag_i, // source on bus
   input  wire logic       input_voltage_loop_flag_i, // vin loop
   input  wire logic       input_current_loop_flag_i, // iin loop
   input  wire logic       const_voltage_loop_flag_i, // cv loop
   input  wire logic       input_overvoltage_flag_i,  // ac ovp
   input  wire logic       top_off_counting_i,  // top-off runs
   input  wire logic       port_detect_complete_i, // detect end
   input  wire logic       switch_reset_request_i, // reset event
   input  wire logic       otg_bus_plug_flag_i, // plug in otg
   input  wire logic       otg_output_enable_i, // otg enabled
   input  wire logic [1:0] boost_voltage_mid_i, // code bits 2:1
   output logic            battery_switch_open_o, // switch off
   output logic            switch_reset_enable_o, // reset allowed
   output logic            switch_full_reset_o,   // reset pulse
   output logic            full_reset_with_adapter_o, // policy
   output logic [1:0]      input_threshold_tracking_o, // track
   output logic            warm_voltage_sel_a_o,  // warm v a
   output logic            warm_voltage_sel_b_o,  // warm v b
   output logic [1:0]      warm_current_sel_o,    // warm current
   output logic [3:0]      boost_voltage_code_o,  // boost code
   output logic [12:0]     boost_voltage_mv_o,    // boost mV
   output logic            sel_a_o,               // sel_a
   output logic            thermistor_ignore_o,   // ntc ignored
   output logic            port_detect_start_o,   // detect pulse
   output logic            safety_timer_reset_o,  // timer reset
   output logic            voltage_loop_irq_o,    // vin pulse
   output logic            current_loop_irq_o     // iin pulse
);
   localparam int SHIP_W = $clog2(SHIP_CYCLES + 1);

   // ----------------------------------------------------------
   // state types
   // ----------------------------------------------------------
   typedef struct packed {
      charger_regs_pkg::status_t s1;
      charger_regs_pkg::status_t s2;
      charger_regs_pkg::status_t sp;
      logic [2:0]        req_s;
      logic              ack_tgl;
      logic              ack;
      logic [7:0]        rdata;
      logic [7:0]        ctrl;
      logic [7:0]        temp;
      logic [7:0]        trim;
      logic [7:0]        det;
      logic [1:0]        irq_mask;
      logic              policy;
      logic              unlocked;
      logic              det_done;
      logic [SHIP_W-1:0] ship_cnt;
      logic              sw_open;
      logic              rst_pend;
      logic              full_rst;
      logic              timer_rst;
      logic              det_start;
      logic              virq;
      logic              cirq;
      logic [3:0]        bcode;
      logic [12:0]       boost_mv;
   } core_t;

   typedef struct packed {
      logic       busy;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       write;
      logic       req_tgl;
      logic [2:0] ack_s;
      logic       resp_valid;
      logic       resp_ack;
      logic [7:0] resp_rdata;
   } link_t;

   core_t q, next_q;
   link_t l, next_l;
   logic [1:0] rst_s;
   logic [1:0] lrst_s;
   logic rst_n;
   logic lrst_n;
   charger_regs_pkg::status_t stat_raw;
   logic acc;
   logic ok;
   logic deny;

   function automatic logic addr_ok(input logic [7:0] a,
                                    input logic       w);
      case (a)
         `ADDR_CTRL, `ADDR_STAT, `ADDR_FAULT, `ADDR_LOOP,
         `ADDR_RST, `ADDR_TEMP, `ADDR_TRIM, `ADDR_DET,
         `ADDR_POLICY: addr_ok = 1'b1;
         `ADDR_OTG: addr_ok = !w;
         `ADDR_PW: addr_ok = w;
         default: addr_ok = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------
   // reset release, one synchroniser per domain
   // ----------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_s <= 2'h0;
      else
         rst_s <= {rst_s[0], 1'b1};
   end
   assign rst_n = rst_s[1];

   always_ff @(posedge link_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         lrst_s <= 2'h0;
      else
         lrst_s <= {lrst_s[0], 1'b1};
   end
   assign lrst_n = lrst_s[1];

   // ----------------------------------------------------------
   // link side: capture, toggle out, wait for answer toggle
   // ----------------------------------------------------------
   always_comb
   begin
      next_l = l;
      next_l.ack_s = {l.ack_s[1:0], q.ack_tgl};
      next_l.resp_valid = 1'b0;
      if (!l.busy && req_valid_i)
      begin
         next_l.busy = 1'b1;
         next_l.addr = req_addr_i;
         next_l.wdata = req_wdata_i;
         next_l.write = req_write_i;
         next_l.req_tgl = ~l.req_tgl;
      end
      // core answer words stay put until the next request
      if (l.busy && (l.ack_s[1] ^ l.ack_s[2]))
      begin
         next_l.busy = 1'b0;
         next_l.resp_valid = 1'b1;
         next_l.resp_ack = q.ack;
         next_l.resp_rdata = q.rdata;
      end
   end

   always_ff @(posedge link_clk_i or negedge lrst_n)
   begin
      if (!lrst_n)
         l <= '0;
      else
         l <= next_l;
   end

   assign req_ready_o = !l.busy;
   assign resp_valid_o = l.resp_valid;
   assign resp_ack_o = l.resp_ack;
   assign resp_rdata_o = l.resp_rdata;

   // ----------------------------------------------------------
   // core side
   // ----------------------------------------------------------
   assign stat_raw = {input_source_type_i, charge_state_i,
      power_good_flag_i, thermal_loop_flag_i,
      min_system_reg_flag_i, watchdog_expired_flag_i,
      bus_overload_i | bus_overvoltage_i | battery_low_i, // R09
      input_fault_i, thermal_shutdown_i, safety_timer_expired_i,
      battery_overvoltage_i, thermistor_zone_i, boost_mode_i,
      bus_attached_flag_i, input_voltage_loop_flag_i,
      input_current_loop_flag_i, const_voltage_loop_flag_i,
      input_overvoltage_flag_i, top_off_counting_i,
      port_detect_complete_i, switch_reset_request_i,
      otg_bus_plug_flag_i};

   assign acc = q.req_s[1] ^ q.req_s[2];
   assign deny = (l.addr == `ADDR_POLICY || l.addr == `ADDR_OTG)
                 && !q.unlocked; // R23
   assign ok = addr_ok(l.addr, l.write) && !deny;

   always_comb
   begin
      charger_regs_pkg::status_t st;
      logic [2:0] zone;
      logic [1:0] cf;
      logic [7:0] rd;
      st = q.s2;
      zone = 3'h0;
      cf = 2'h0;
      rd = 8'h00;
      next_q = q;
      next_q.s1 = stat_raw;
      next_q.s2 = q.s1;
      next_q.sp = q.s2;
      next_q.req_s = {q.req_s[1:0], l.req_tgl};
      next_q.full_rst = 1'b0;
      next_q.timer_rst = 1'b0;
      next_q.det_start = 1'b0;
      // thermistor zone as reported
      zone = st.zone;
      if (q.det[`BIT_NTC])
         zone = charger_regs_pkg::ZONE_NORMAL; // R22
      else if (st.boost_mode &&
               (zone == charger_regs_pkg::ZONE_WARM ||
                zone == charger_regs_pkg::ZONE_COOL))
         zone = charger_regs_pkg::ZONE_NORMAL; // R11
      // the most severe charge fault wins when several stand
      if (st.thermal_shdn)
         cf = charger_regs_pkg::CF_THERMAL; // R10
      else if (st.timer_expired)
         cf = charger_regs_pkg::CF_TIMER;
      else if (st.input_fault)
         cf = charger_regs_pkg::CF_INPUT;
      else
         cf = charger_regs_pkg::CF_NONE;
      // read mux; reserved bits are zero
      case (l.addr)
         `ADDR_CTRL: rd = q.ctrl;
         `ADDR_STAT: rd = {st.source_type, st.charge_state,
            st.power_good, st.thermal_loop, st.min_sys}; // R05 R06 R07
         `ADDR_FAULT: rd = {st.wd_expired, st.boost_block, cf,
            st.bat_ovp, zone}; // R08 R09
         `ADDR_LOOP: rd = {st.bus_attached, st.v_loop, st.i_loop,
            st.cv_loop, st.top_off, st.acov, q.irq_mask}; // R12 R13 R14
         `ADDR_RST: rd = {1'b0, 4'h5, 1'b0, 2'h0}; // id arbitrary
         `ADDR_TEMP: rd = q.temp;
         `ADDR_TRIM: rd = q.trim;
         `ADDR_DET: rd = {q.det[7], q.det_done, q.det[5:0]};
         `ADDR_POLICY: rd = {q.policy, 7'h00}; // R25
         `ADDR_OTG: rd = {7'h00, st.otg_plug}; // R25
         default: rd = 8'h00;
      endcase
      // forced detection bit clears itself after one cycle
      if (q.ctrl[`BIT_FORCE])
      begin
         next_q.ctrl[`BIT_FORCE] = 1'b0;
         next_q.det_start = 1'b1;
         next_q.det_done = 1'b0;
      end
      if (acc)
      begin
         next_q.ack_tgl = ~q.ack_tgl;
         next_q.ack = ok;
         next_q.rdata = (ok && !l.write) ? rd : 8'h00;
         if (ok && l.write)
         begin
            case (l.addr)
               `ADDR_CTRL: next_q.ctrl = l.wdata;
               `ADDR_LOOP: next_q.irq_mask = l.wdata[1:0];
               `ADDR_TEMP: next_q.temp = l.wdata;
               `ADDR_TRIM: next_q.trim = l.wdata;
               `ADDR_DET:
               begin
                  next_q.det = l.wdata;
                  next_q.det[`BIT_DONE] = 1'b0; // R25
                  if (otg_output_enable_i)
                     next_q.det[`BIT_FREQ] = q.det[`BIT_FREQ]; // R19
               end
               `ADDR_POLICY: next_q.policy = l.wdata[7];
               `ADDR_PW: next_q.unlocked = (l.wdata == `PW_VALUE); // R23
               `ADDR_RST:
               begin
                  if (l.wdata[`BIT_REGRST])
                  begin
                     next_q.ctrl = `RST_CTRL; // R16
                     next_q.temp = `RST_TEMP;
                     next_q.trim = `RST_TRIM;
                     next_q.det = `RST_DET;
                     next_q.irq_mask = 2'h0;
                     next_q.policy = 1'b0;
                     next_q.timer_rst = 1'b1;
                  end
               end
               default: next_q.unlocked = q.unlocked;
            endcase
         end
      end
      // port detection on plug-in; completion set wins over clear
      if (q.det[`BIT_AUTO] && st.bus_attached && !q.sp.bus_attached)
      begin
         next_q.det_start = 1'b1; // R20
         next_q.det_done = 1'b0;
      end
      if (st.detect_cmpl && !q.sp.detect_cmpl)
         next_q.det_done = 1'b1; // R20
      // battery switch; the ship delay restarts if the bit drops
      if (!q.ctrl[`BIT_OFF])
      begin
         next_q.sw_open = 1'b0; // R24
         next_q.ship_cnt = '0;
      end
      else if (!q.ctrl[`BIT_DLY])
         next_q.sw_open = 1'b1; // R01
      else if (q.ship_cnt == SHIP_W'(SHIP_CYCLES - 1))
         next_q.sw_open = 1'b1; // R01
      else
         next_q.ship_cnt = q.ship_cnt + 1'b1;
      // full reset waits for the adapter condition of the policy
      if (q.rst_pend && (q.policy == st.bus_attached))
      begin
         next_q.full_rst = 1'b1; // R21
         next_q.rst_pend = 1'b0;
      end
      if (st.sw_rst_req && !q.sp.sw_rst_req && q.ctrl[`BIT_RSTEN])
         next_q.rst_pend = 1'b1; // R02
      next_q.virq = st.v_loop && !q.sp.v_loop && !q.irq_mask[1]; // R15
      next_q.cirq = st.i_loop && !q.sp.i_loop && !q.irq_mask[0]; // R15
      next_q.bcode = {q.trim[2], boost_voltage_mid_i, q.trim[1]};
      next_q.boost_mv = 13'(`BOOST_BASE_MV +
                            `BOOST_STEP_MV * q.bcode); // R18
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.ctrl <= `RST_CTRL;
         q.temp <= `RST_TEMP;
         q.trim <= `RST_TRIM;
         q.det <= `RST_DET;
         q.bcode <= 4'hc;
         q.boost_mv <= 13'h13ec;
      end
      else
         q <= next_q;
   end

   assign battery_switch_open_o = q.sw_open;
   assign switch_reset_enable_o = q.ctrl[`BIT_RSTEN];
   assign switch_full_reset_o = q.full_rst;
   assign full_reset_with_adapter_o = q.policy;
   assign input_threshold_tracking_o = q.ctrl[1:0]; // R03
   assign warm_voltage_sel_a_o = q.ctrl[4]; // R04
   assign warm_voltage_sel_b_o = q.temp[6]; // R04
   assign warm_current_sel_o = q.temp[5:4]; // R17
   assign boost_voltage_code_o = q.bcode;
   assign boost_voltage_mv_o = q.boost_mv;
   assign sel_a_o = q.det[`BIT_FREQ];
   assign thermistor_ignore_o = q.det[`BIT_NTC];
   assign port_detect_start_o = q.det_start;
   assign safety_timer_reset_o = q.timer_rst;
   assign voltage_loop_irq_o = q.virq;
   assign current_loop_irq_o = q.cirq;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   AST_SHIP_NOW: assert property ( // R01
      q.ctrl[`BIT_OFF] && !q.ctrl[`BIT_DLY] |=> q.sw_open)
      else $error("switch not opened at once");
   AST_SHIP_WAIT: assert property ( // R01
      $rose(q.sw_open) && $past(q.ctrl[`BIT_DLY]) |->
      $past(q.ship_cnt) == SHIP_W'(SHIP_CYCLES - 1))
      else $error("switch opened before ship delay");
   AST_CLOSE: assert property ( // R24
      !q.ctrl[`BIT_OFF] |=> !q.sw_open)
      else $error("switch held open while allowed");
   AST_RST_GATE: assert property ( // R02
      $rose(q.rst_pend) |-> $past(q.ctrl[`BIT_RSTEN]))
      else $error("switch reset taken while disabled");
   AST_POLICY: assert property ( // R21
      q.full_rst |-> $past(q.policy) == $past(q.s2.bus_attached))
      else $error("full reset against adapter policy");
   AST_FREQ: assert property ( // R19
      acc && ok && l.write && l.addr == `ADDR_DET &&
      otg_output_enable_i |=> $stable(q.det[`BIT_FREQ]))
      else $error("boost frequency changed in otg");
   AST_REGRST: assert property ( // R16
      acc && ok && l.write && l.addr == `ADDR_RST &&
      l.wdata[`BIT_REGRST] |=>
      q.temp == `RST_TEMP && q.timer_rst ##1 !q.timer_rst)
      else $error("register reset incomplete");
   AST_PW: assert property ( // R23
      acc && !q.unlocked &&
      (l.addr == `ADDR_POLICY || l.addr == `ADDR_OTG) |=> !q.ack)
      else $error("locked register answered");
   AST_MASK: assert property ( // R15
      q.virq |-> !$past(q.irq_mask[1]))
      else $error("masked voltage loop pulse");
   AST_ZONE: assert property ( // R22
      acc && ok && !l.write && l.addr == `ADDR_FAULT &&
      q.det[`BIT_NTC] |=> q.rdata[2:0] == 3'h0)
      else $error("thermistor fault shown while ignored");
endmodule

// [core/charger_regs_cfg.svh]
// constants of the charger control and status register bank
//
// Summary of operation
// R01: switch-off bit opens battery switch at once, or after ship delay.
// R02: battery-switch reset acts only while its enable bit is one; code samples the bit at the request edge, a pending reset still fires.
// R03: tracking field picks off, or battery plus 200/250/300 mV threshold.
// R04: warm voltage: minus 200 mV or none; second bit gives 100/50 mV.
// R05: source field reports none, SDP, CDP, DCP, reserved, unknown, other, OTG.
// R06: charge state reads idle, trickle, fast, terminated as 00..11.
// R07: read-only bits show power good, thermal loop, min-system loop.
// R08: watchdog fault bit reads one after watchdog expiry.
// R09: boost fault on bus overload, bus overvoltage or low battery.
// R10: charge fault reads normal, input fault, thermal shutdown, timer expiry.
// R11: thermistor code shows five charge zones, only normal/cold/hot in boost.
// R12: bus attached bit reads one while a source is on the bus.
// R13: loop bits show input-voltage, input-current, CV loops and overvoltage.
// R14: top-off bit reads one while the top-off timer runs.
// R15: two mask bits suppress the voltage and current loop pulses.
// R16: register reset restores defaults, resets safety timer, self-clears.
// R17: warm current field gives none, 20%, 50% or 100% of charge current.
// R18: boost voltage is 3.9 V plus 100 mV times scattered four-bit code.
// R19: boost frequency writes ignored while OTG enabled; 0 fast, 1 slow.
// R20: auto detect runs port detection on plug-in, sets a done bit.
// R21: full reset starts after adapter removal, or with adapter present.
// R22: thermistor-ignore bit treats temperature as good in all modes.
// R23: registers 0x80 and 0x82 are denied until a password arrives.
// R24: switch-off bit zero lets switch conduct, one commands it off.
// R25: reserved bits read zero and ignore writes.
`ifndef CHARGER_REGS_CFG_SVH
`define CHARGER_REGS_CFG_SVH
`define ADDR_CTRL    8'h07
`define ADDR_STAT    8'h08
`define ADDR_FAULT   8'h09
`define ADDR_LOOP    8'h0a
`define ADDR_RST     8'h0b
`define ADDR_TEMP    8'h0c
`define ADDR_TRIM    8'h0d
`define ADDR_DET     8'h0e
`define ADDR_POLICY  8'h80
`define ADDR_OTG     8'h82
`define ADDR_PW      8'h7f
`define PW_VALUE     8'h5a
`define RST_CTRL     8'h44
`define RST_TEMP     8'h35
`define RST_TRIM     8'h24
`define RST_DET      8'hb2
`define BIT_FORCE    7
`define BIT_OFF      5
`define BIT_DLY      3
`define BIT_RSTEN    2
`define BIT_DONE     6
`define BIT_AUTO     5
`define BIT_FREQ     3
`define BIT_NTC      0
`define BIT_REGRST   7
`define SHIP_DLY_S   10
`define CLK_HZ       20000000
`define BOOST_BASE_MV 3900
`define BOOST_STEP_MV 100
`endif

// [core/charger_regs_pkg.sv]
// types shared by the charger register bank
package charger_regs_pkg;
   typedef enum logic [2:0] {
      ZONE_NORMAL = 3'h0,
      ZONE_WARM   = 3'h2,
      ZONE_COOL   = 3'h3,
      ZONE_COLD   = 3'h5,
      ZONE_HOT    = 3'h6
   } zone_t;
   typedef enum logic [1:0] {
      CF_NONE    = 2'h0,
      CF_INPUT   = 2'h1,
      CF_THERMAL = 2'h2,
      CF_TIMER   = 2'h3
   } cfault_t;
   typedef struct packed {
      logic [2:0] source_type;
      logic [1:0] charge_state;
      logic       power_good;
      logic       thermal_loop;
      logic       min_sys;
      logic       wd_expired;
      logic       boost_block;
      logic       input_fault;
      logic       thermal_shdn;
      logic       timer_expired;
      logic       bat_ovp;
      logic [2:0] zone;
      logic       boost_mode;
      logic       bus_attached;
      logic       v_loop;
      logic       i_loop;
      logic       cv_loop;
      logic       acov;
      logic       top_off;
      logic       detect_cmpl;
      logic       sw_rst_req;
      logic       otg_plug;
   } status_t;
endpackage

// [test/link_host.sv]
// host model that drives the register access port
`timescale 1ns/1ns
module link_host (
   input  wire logic       clk_i,   // port clock
   input  wire logic       ready_i, // port idle
   input  wire logic       resp_i,  // answer pulse
   output logic            valid_o, // request
   output logic            write_o, // 1 write, 0 read
   output logic [7:0]      addr_o,  // address
   output logic [7:0]      wdata_o  // write data
);
   initial
      {valid_o, write_o, addr_o, wdata_o} = '0;
   // one request at a time, held until the port takes it
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
      int n;
      @(negedge clk_i);
      {valid_o, write_o, addr_o, wdata_o} = {1'h1, w, a, d};
      do
         @(posedge clk_i);
      while (ready_i !== 1'h1);
      @(negedge clk_i);
      // released lines invert so a stale value cannot match by luck
      {valid_o, addr_o, wdata_o} = {1'h0, ~a, ~d};
      n = 0;
      while (resp_i !== 1'h1 && n < 40)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask
endmodule

// [test/tb.sv]
// self-checking bench of the charger register bank
`timescale 1ns/1ns
module tb;
   logic clk = 1'h0, lclk = 1'h0, rstn = 1'h0;
   logic [2:0] src, zone;
   logic [1:0] cst, mid;
   logic pg, th, vs, wd, ovl, bov, blo, inf, tsd, tmr, bovp, bm, ba, vl;
   logic il, cv, acov, top, pdc, srr, otgp, otge;
   logic rv, rw, rdy, rsp, ack, open, sela, str, vi, ci, fr;
   logic [7:0] ra, wd8, rdat;
   logic [3:0] code;
   logic [12:0] mv;
   logic [8:0] expq[$];
   logic [2:0] zt[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
   int bad_count = 0, n_tests = 0, n_str = 0, n_vi = 0, n_ci = 0;
   int n_fr = 0;
   // ------------------------------------------------------------
   // harness
   // ------------------------------------------------------------
   initial
      forever #25 clk = ~clk;
   initial
   begin
      #7;
      forever #15 lclk = ~lclk;
   end
   charger_status_control_regs #(.SHIP_CYCLES(40)) dut (
      .clk_i(clk), .rstn_i(rstn), .link_clk_i(lclk), .req_valid_i(rv),
      .req_write_i(rw), .req_addr_i(ra), .req_wdata_i(wd8),
      .req_ready_o(rdy), .resp_valid_o(rsp), .resp_ack_o(ack),
      .resp_rdata_o(rdat), .input_source_type_i(src),
      .charge_state_i(cst), .power_good_flag_i(pg),
      .thermal_loop_flag_i(th), .min_system_reg_flag_i(vs),
      .watchdog_expired_flag_i(wd), .bus_overload_i(ovl),
      .bus_overvoltage_i(bov), .battery_low_i(blo), .input_fault_i(inf),
      .thermal_shutdown_i(tsd), .safety_timer_expired_i(tmr),
      .battery_overvoltage_i(bovp), .thermistor_zone_i(zone),
      .boost_mode_i(bm), .bus_attached_flag_i(ba),
      .input_voltage_loop_flag_i(vl), .input_current_loop_flag_i(il),
      .const_voltage_loop_flag_i(cv), .input_overvoltage_flag_i(acov),
      .top_off_counting_i(top), .port_detect_complete_i(pdc),
      .switch_reset_request_i(srr), .otg_bus_plug_flag_i(otgp),
      .otg_output_enable_i(otge), .boost_voltage_mid_i(mid),
      .battery_switch_open_o(open), .switch_reset_enable_o(),
      .switch_full_reset_o(fr), .full_reset_with_adapter_o(),
      .input_threshold_tracking_o(), .warm_voltage_sel_a_o(),
      .warm_voltage_sel_b_o(), .warm_current_sel_o(),
      .boost_voltage_code_o(code), .boost_voltage_mv_o(mv),
      .sel_a_o(sela), .thermistor_ignore_o(), .port_detect_start_o(),
      .safety_timer_reset_o(str), .voltage_loop_irq_o(vi),
      .current_loop_irq_o(ci));
   link_host host (.clk_i(lclk), .ready_i(rdy), .resp_i(rsp),
      .valid_o(rv), .write_o(rw), .addr_o(ra), .wdata_o(wd8));
   task automatic check(string nm, logic [12:0] seen, logic [12:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(logic w, logic [7:0] a, d, logic [8:0] e);
      expq.push_back(e);
      host.xfer(w, a, d);
   endtask
   task automatic hold(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // masked loop flags must give no pulse, unmasked exactly one
   task automatic loops(logic [7:0] m, int ev, int ec);
      hold(1);
      {vl, il} = 2'h0;
      acc(1, 8'h0a, m, 9'h100);
      hold(6);
      {n_vi, n_ci} = '0;
      {vl, il} = 2'h3;
      hold(8);
      check("voltage loop pulses", n_vi, ev);
      check("current loop pulses", n_ci, ec);
   endtask
   always @(posedge lclk)
      if (rsp === 1'h1)
         check("response", {ack, rdat}, expq.pop_front());
   always @(posedge clk)
   begin
      n_str += int'(str === 1'h1);
      n_fr += int'(fr === 1'h1);
      n_vi += int'(vi === 1'h1);
      n_ci += int'(ci === 1'h1);
   end
   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      {pg, th, vs, wd, ovl, bov, blo, inf, tsd, tmr, bovp, bm} = '0;
      {ba, vl, il, cv, acov, top, pdc, srr, otgp, otge} = '0;
      {src, zone, cst, mid} = '0;
      void'($urandom(42809));
      hold(3);
      rstn = 1'h1;
      repeat (6) @(posedge lclk);
      acc(0, 8'h07, 8'h00, 9'h144);
      acc(0, 8'h0c, 8'h00, 9'h135);
      acc(0, 8'h0d, 8'h00, 9'h124);
      acc(0, 8'h0b, 8'h00, 9'h128);
      for (int i = 0; i < 5; i++)
      begin
         hold(1);
         {src, pg, th, vs, wd, ovl, bov, blo, bovp} = 11'($urandom);
         {ba, vl, il, cv, top, acov} = 6'($urandom);
         {cst, zone} = {2'(i), zt[i]};
         {inf, tsd, tmr} = {i == 1, i == 2, i == 3};
         hold(8);
         acc(0, 8'h08, 8'h00, {1'h1, src, cst, pg, th, vs});
         acc(0, 8'h09, 8'h00, {1'h1, wd, ovl | bov | blo, 2'(i % 4),
             bovp, zone});
         acc(0, 8'h0a, 8'h00, {1'h1, ba, vl, il, cv, top, acov, 2'h0});
      end
      acc(1, 8'h0e, 8'hb3, 9'h100);
      acc(0, 8'h09, 8'h00, {1'h1, wd, ovl | bov | blo, 2'h0,
          bovp, 3'h0});
      acc(1, 8'h0e, 8'hb2, 9'h100);
      $display("status reporting done");
      acc(0, 8'h80, 8'h00, 9'h000);
      acc(1, 8'h7f, 8'h5a, 9'h100);
      acc(1, 8'h80, 8'hff, 9'h100);
      acc(0, 8'h80, 8'h00, 9'h180);
      hold(1);
      otgp = 1'h1;
      hold(8);
      acc(0, 8'h82, 8'h00, 9'h101);
      acc(1, 8'h82, 8'h01, 9'h000);
      acc(0, 8'h00, 8'h00, 9'h000);
      $display("access control done");
      acc(1, 8'h07, 8'h24, 9'h100);
      hold(2);
      check("switch open", open, 1);
      acc(1, 8'h07, 8'h44, 9'h100);
      hold(2);
      check("switch closed", open, 0);
      acc(1, 8'h07, 8'h2c, 9'h100);
      hold(2);
      check("switch delayed", open, 0);
      hold(45);
      check("switch opened late", open, 1);
      acc(1, 8'h07, 8'h44, 9'h100);
      $display("battery switch done");
      loops(8'hfe, 0, 1);
      loops(8'h01, 1, 0);
      $display("loop masks done");
      acc(1, 8'h0c, 8'h00, 9'h100);
      acc(0, 8'h0c, 8'h00, 9'h100);
      n_str = 0;
      acc(1, 8'h0b, 8'h80, 9'h100);
      hold(2);
      check("timer reset pulses", n_str, 1);
      acc(0, 8'h0c, 8'h00, 9'h135);
      acc(0, 8'h0b, 8'h00, 9'h128);
      $display("register reset done");
      hold(1);
      otge = 1'h1;
      acc(1, 8'h0e, 8'hba, 9'h100);
      acc(0, 8'h0e, 8'h00, 9'h1b2);
      hold(1);
      {otge, mid} = {1'h0, 2'h3};
      acc(1, 8'h0e, 8'hba, 9'h100);
      hold(3);
      check("boost frequency", sela, 1);
      check("boost code", code, {1'h1, mid, 1'h0});
      check("boost mv", mv, 13'(3900 + 100 * {1'h1, mid, 1'h0}));
      hold(1);
      pdc = 1'h1;
      hold(8);
      acc(0, 8'h0e, 8'h00, 9'h1fa);
      {ba, srr} = 2'h1;
      hold(8);
      check("full reset pulses", n_fr, 1);
      $display("boost and detect done");
      end_of_test();
   end
endmodule
